// ===== src/pfcc_pkg.sv
// How it works
// - The first feedback divider is a 15-bit binary divide value from 1 to 32,767 that resets to 512.
// - The first feedback divider runs while its power-down bit is 0 and stops while it is 1, resetting to 0.
// - Lock is reported only after the phase difference stays within the window for more than the selected tick count.
// - The 2-bit count selector picks 10,000, 100,000, 1,000,000 or 10,000,000 feedback ticks, 00 at reset.
// - The second feedback divider is a 14-bit value from 1 to 16,383 resetting to 50, advised 8 or more above 1GHz.
// - Path select 1 uses the first divider alone (times two when the prescaler is on), else both dividers in series.
// - The feedback phase delay is the 12-bit code times 254ps over 4096 steps, code 0 meaning none, 0 at reset.
// - The second feedback divider runs while its power-down bit is 0 and stops at 1; software keeps it 0 for monitoring.
// - The charge pump runs while its power bit is 0 and is powered down and disabled at 1, resetting to 0.
// - The pump sink current, equal to the source, is on when its enable is 1 and off at 0, resetting to 1.
// - The pump gain step is 100uA with the multiplier bit at 0 and 200uA at 1, resetting to 1.
// - With the multiplier at 0 the pump current is 800, 400, 200 and 100uA for gain bits 3 down to 0.
// - With the multiplier at 1 the pump current is 1600uA plus 800, 400 and 200uA for gain bits 2, 1 and 0.
// - The force bit, 1 at reset, holds the control voltage at mid-supply and the loop unlocked until software clears it.
package pfcc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_LOCK_COUNT   = 8'h13;
    localparam logic [7:0] ADDR_FIRST_DIV_LO = 8'h14;
    localparam logic [7:0] ADDR_FIRST_DIV_HI = 8'h15;
    localparam logic [7:0] ADDR_WINDOW_LO    = 8'h16;
    localparam logic [7:0] ADDR_WINDOW_HI    = 8'h17;
    localparam logic [7:0] ADDR_SECOND_LO    = 8'h18;
    localparam logic [7:0] ADDR_SECOND_HI    = 8'h19;
    localparam logic [7:0] ADDR_PHASE_LO     = 8'h1A;
    localparam logic [7:0] ADDR_PHASE_HI     = 8'h1B;
    localparam logic [7:0] ADDR_PUMP_CTRL    = 8'h1C;
    localparam logic [7:0] ADDR_PUMP_POL     = 8'h1D;
    localparam logic [7:0] ADDR_PREDIV       = 8'h21;

    // Field positions inside their bytes
    localparam int LOCK_COUNT_LSB = 4;
    localparam int POWERDOWN_BIT  = 7;
    localparam int PATH_SEL_BIT   = 7;
    localparam int PUMP_OFF_BIT   = 7;
    localparam int PUMP_SINK_BIT  = 5;
    localparam int PUMP_X2_BIT    = 4;
    localparam int PUMP_POL_BIT   = 7;
    localparam int FORCE_MID_BIT  = 6;
    localparam int PREDIV_BIT     = 7;

    // Values after reset
    localparam logic [14:0] RST_FIRST_DIV   = 15'h0200;
    localparam logic [14:0] RST_WINDOW      = 15'h0100;
    localparam logic [13:0] RST_SECOND_DIV  = 14'h0032;
    localparam logic [11:0] RST_PHASE       = 12'h000;
    localparam logic [1:0]  RST_LOCK_COUNT  = 2'h0;
    localparam logic        RST_OFF         = 1'b0;
    localparam logic        RST_PATH_SEL    = 1'b1;
    localparam logic        RST_PUMP_SINK   = 1'b1;
    localparam logic        RST_PUMP_X2     = 1'b1;
    localparam logic [3:0]  RST_PUMP_GAIN   = 4'h0;
    localparam logic        RST_PUMP_POL    = 1'b0;
    localparam logic        RST_FORCE_MID   = 1'b1;
    localparam logic [5:0]  RST_PUMP_OFFSET = 6'h00;
    localparam logic        RST_PREDIV      = 1'b1;

    // Lock qualification counts in feedback ticks
    localparam int LOCK_TICKS_0 = 10000;
    localparam int LOCK_TICKS_1 = 100000;
    localparam int LOCK_TICKS_2 = 1000000;
    localparam int LOCK_TICKS_3 = 10000000;

    // Analog scaling
    localparam int PHASE_STEP_PS  = 254;
    localparam int PUMP_STEP_UA   = 100;
    localparam int PUMP_BASE_X2UA = 1600;

    // Lock detector states
    typedef enum logic [2:0] {
        PFCC_UNLOCKED = 3'b001,
        PFCC_COUNTING = 3'b010,
        PFCC_LOCKED   = 3'b100
    } pfcc_lock_t;
endpackage

// ===== src/pfcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfcc_top
    import pfcc_pkg::*;
#(
    parameter logic [23:0] P_LOCK_TICKS_0 = 24'(LOCK_TICKS_0),
    parameter logic [23:0] P_LOCK_TICKS_1 = 24'(LOCK_TICKS_1),
    parameter logic [23:0] P_LOCK_TICKS_2 = 24'(LOCK_TICKS_2),
    parameter logic [23:0] P_LOCK_TICKS_3 = 24'(LOCK_TICKS_3)
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_reg_rvalid,
    input  wire logic        i_fb_tick,
    input  wire logic [14:0] i_phase_diff,
    output logic             o_first_locked,
    output logic      [14:0] o_first_fb_div,
    output logic             o_first_fb_div_run,
    output logic      [13:0] o_second_fb_div,
    output logic             o_second_fb_div_run,
    output logic      [29:0] o_fb_total_div,
    output logic      [20:0] o_fb_phase_delay_ps,
    output logic             o_pump_run,
    output logic             o_pump_sink_on,
    output logic      [11:0] o_pump_current_ua,
    output logic      [5:0]  o_pump_offset_current,
    output logic             o_pump_polarity,
    output logic             o_force_mid_voltage
);

    // Pump current from gain code and step multiplier
    function automatic logic [11:0] pump_ua(input logic [3:0] gain, input logic dbl);
        logic [11:0] base;
        base = 12'(PUMP_STEP_UA);
        if (dbl) begin
            pump_ua = 12'(PUMP_BASE_X2UA) + 12'({1'b0, gain[2:0]}) * base * 12'h002;
        end else begin
            pump_ua = 12'(gain) * base;
        end
    endfunction

    // Lock tick target for the selector
    function automatic logic [23:0] lock_target(input logic [1:0] sel);
        case (sel)
            2'h0:    lock_target = P_LOCK_TICKS_0;
            2'h1:    lock_target = P_LOCK_TICKS_1;
            2'h2:    lock_target = P_LOCK_TICKS_2;
            default: lock_target = P_LOCK_TICKS_3;
        endcase
    endfunction

    logic [14:0] first_fb_div_reg;
    logic        first_fb_div_off_reg;
    logic [14:0] lock_window_reg;
    logic [1:0]  lock_count_sel_reg;
    logic [13:0] second_fb_div_reg;
    logic        feedback_path_select_reg;
    logic [11:0] fb_phase_delay_reg;
    logic        second_fb_div_off_reg;
    logic        pump_off_reg;
    logic        pump_sink_on_reg;
    logic        pump_step_double_reg;
    logic [3:0]  pump_gain_reg;
    logic        pump_polarity_reg;
    logic        force_mid_voltage_reg;
    logic [5:0]  pump_offset_current_reg;
    logic        osc_prediv_select_reg;

    // Write strobes per address
    wire wr_lock_count = i_reg_wr && (i_reg_addr == ADDR_LOCK_COUNT);
    wire wr_first_lo   = i_reg_wr && (i_reg_addr == ADDR_FIRST_DIV_LO);
    wire wr_first_hi   = i_reg_wr && (i_reg_addr == ADDR_FIRST_DIV_HI);
    wire wr_window_lo  = i_reg_wr && (i_reg_addr == ADDR_WINDOW_LO);
    wire wr_window_hi  = i_reg_wr && (i_reg_addr == ADDR_WINDOW_HI);
    wire wr_second_lo  = i_reg_wr && (i_reg_addr == ADDR_SECOND_LO);
    wire wr_second_hi  = i_reg_wr && (i_reg_addr == ADDR_SECOND_HI);
    wire wr_phase_lo   = i_reg_wr && (i_reg_addr == ADDR_PHASE_LO);
    wire wr_phase_hi   = i_reg_wr && (i_reg_addr == ADDR_PHASE_HI);
    wire wr_pump_ctrl  = i_reg_wr && (i_reg_addr == ADDR_PUMP_CTRL);
    wire wr_pump_pol   = i_reg_wr && (i_reg_addr == ADDR_PUMP_POL);
    wire wr_prediv     = i_reg_wr && (i_reg_addr == ADDR_PREDIV);

    // Configuration registers, defaults on reset
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            first_fb_div_reg         <= RST_FIRST_DIV;
            first_fb_div_off_reg     <= RST_OFF;
            lock_window_reg          <= RST_WINDOW;
            lock_count_sel_reg       <= RST_LOCK_COUNT;
            second_fb_div_reg        <= RST_SECOND_DIV;
            feedback_path_select_reg <= RST_PATH_SEL;
            fb_phase_delay_reg       <= RST_PHASE;
            second_fb_div_off_reg    <= RST_OFF;
            pump_off_reg             <= RST_OFF;
            pump_sink_on_reg         <= RST_PUMP_SINK;
            pump_step_double_reg     <= RST_PUMP_X2;
            pump_gain_reg            <= RST_PUMP_GAIN;
            pump_polarity_reg        <= RST_PUMP_POL;
            force_mid_voltage_reg    <= RST_FORCE_MID;
            pump_offset_current_reg  <= RST_PUMP_OFFSET;
            osc_prediv_select_reg    <= RST_PREDIV;
        end else begin
            if (wr_lock_count) lock_count_sel_reg <= i_reg_wdata[LOCK_COUNT_LSB +: 2];
            if (wr_first_lo) first_fb_div_reg[7:0] <= i_reg_wdata;
            if (wr_first_hi) begin
                first_fb_div_reg[14:8] <= i_reg_wdata[6:0];
                first_fb_div_off_reg   <= i_reg_wdata[POWERDOWN_BIT];
            end
            if (wr_window_lo) lock_window_reg[7:0] <= i_reg_wdata;
            if (wr_window_hi) lock_window_reg[14:8] <= i_reg_wdata[6:0];
            if (wr_second_lo) second_fb_div_reg[7:0] <= i_reg_wdata;
            if (wr_second_hi) begin
                second_fb_div_reg[13:8]  <= i_reg_wdata[5:0];
                feedback_path_select_reg <= i_reg_wdata[PATH_SEL_BIT];
            end
            if (wr_phase_lo) fb_phase_delay_reg[7:0] <= i_reg_wdata;
            if (wr_phase_hi) begin
                fb_phase_delay_reg[11:8] <= i_reg_wdata[3:0];
                second_fb_div_off_reg    <= i_reg_wdata[POWERDOWN_BIT];
            end
            if (wr_pump_ctrl) begin
                pump_off_reg         <= i_reg_wdata[PUMP_OFF_BIT];
                pump_sink_on_reg     <= i_reg_wdata[PUMP_SINK_BIT];
                pump_step_double_reg <= i_reg_wdata[PUMP_X2_BIT];
                pump_gain_reg        <= i_reg_wdata[3:0];
            end
            if (wr_pump_pol) begin
                pump_polarity_reg       <= i_reg_wdata[PUMP_POL_BIT];
                force_mid_voltage_reg   <= i_reg_wdata[FORCE_MID_BIT];
                pump_offset_current_reg <= i_reg_wdata[5:0];
            end
            if (wr_prediv) osc_prediv_select_reg <= i_reg_wdata[PREDIV_BIT];
        end
    end

    // Read-back mux, reserved bits and unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (i_reg_addr)
            ADDR_LOCK_COUNT:   rd_mux = {2'h0, lock_count_sel_reg, 4'h0};
            ADDR_FIRST_DIV_LO: rd_mux = first_fb_div_reg[7:0];
            ADDR_FIRST_DIV_HI: rd_mux = {first_fb_div_off_reg, first_fb_div_reg[14:8]};
            ADDR_WINDOW_LO:    rd_mux = lock_window_reg[7:0];
            ADDR_WINDOW_HI:    rd_mux = {1'b0, lock_window_reg[14:8]};
            ADDR_SECOND_LO:    rd_mux = second_fb_div_reg[7:0];
            ADDR_SECOND_HI:    rd_mux = {feedback_path_select_reg, 1'b0, second_fb_div_reg[13:8]};
            ADDR_PHASE_LO:     rd_mux = fb_phase_delay_reg[7:0];
            ADDR_PHASE_HI:     rd_mux = {second_fb_div_off_reg, 3'h0, fb_phase_delay_reg[11:8]};
            ADDR_PUMP_CTRL:    rd_mux = {pump_off_reg, 1'b0, pump_sink_on_reg, pump_step_double_reg, pump_gain_reg};
            ADDR_PUMP_POL:     rd_mux = {pump_polarity_reg, force_mid_voltage_reg, pump_offset_current_reg};
            ADDR_PREDIV:       rd_mux = {osc_prediv_select_reg, 7'h00};
            default:           rd_mux = 8'h00;
        endcase
    end

    // Read data registered, valid one cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) o_reg_rdata <= rd_mux;
        end
    end

    // Lock detector
    pfcc_lock_t  lock_state_reg;
    pfcc_lock_t  lock_state_next;
    logic [23:0] lock_cnt_reg;
    logic [23:0] lock_cnt_next;

    wire         lock_hold   = force_mid_voltage_reg || first_fb_div_off_reg;
    wire         in_window   = i_phase_diff <= lock_window_reg;
    wire [23:0]  lock_goal   = lock_target(lock_count_sel_reg);
    wire         good_tick   = i_fb_tick && in_window;
    wire         bad_tick    = i_fb_tick && !in_window;

    // Next state: count qualifying ticks, lock once the count is exceeded
    always_comb begin
        lock_state_next = lock_state_reg;
        lock_cnt_next   = lock_cnt_reg;
        case (lock_state_reg)
            PFCC_UNLOCKED: begin
                lock_cnt_next = 24'h000000;
                if (!lock_hold && good_tick) begin
                    lock_cnt_next   = 24'h000001;
                    lock_state_next = PFCC_COUNTING;
                end
            end
            PFCC_COUNTING: begin
                if (lock_hold || bad_tick) begin
                    lock_state_next = PFCC_UNLOCKED;
                end else if (good_tick) begin
                    if (lock_cnt_reg >= lock_goal) begin
                        lock_state_next = PFCC_LOCKED;
                    end else begin
                        lock_cnt_next = lock_cnt_reg + 24'h000001;
                    end
                end
            end
            PFCC_LOCKED: begin
                if (lock_hold || bad_tick) begin
                    lock_state_next = PFCC_UNLOCKED;
                end
            end
            default: begin
                lock_state_next = PFCC_UNLOCKED;
                lock_cnt_next   = 24'h000000;
            end
        endcase
    end

    // Lock state flops
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lock_state_reg <= PFCC_UNLOCKED;
            lock_cnt_reg   <= 24'h000000;
        end else begin
            lock_state_reg <= lock_state_next;
            lock_cnt_reg   <= lock_cnt_next;
        end
    end

    // Derived analog settings
    wire [29:0] path_div_next = feedback_path_select_reg ?
        (osc_prediv_select_reg ? {14'h0000, first_fb_div_reg, 1'b0} : {15'h0000, first_fb_div_reg})
        : 30'(first_fb_div_reg) * 30'(second_fb_div_reg);
    wire [20:0] phase_ps_next = 21'(fb_phase_delay_reg) * 21'(PHASE_STEP_PS);
    wire [11:0] pump_ua_next  = pump_ua(pump_gain_reg, pump_step_double_reg);

    // Registered outputs
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_first_locked        <= 1'b0;
            o_first_fb_div        <= RST_FIRST_DIV;
            o_first_fb_div_run    <= 1'b0;
            o_second_fb_div       <= RST_SECOND_DIV;
            o_second_fb_div_run   <= 1'b0;
            o_fb_total_div        <= 30'h00000000;
            o_fb_phase_delay_ps   <= 21'h000000;
            o_pump_run            <= 1'b0;
            o_pump_sink_on        <= 1'b0;
            o_pump_current_ua     <= 12'h000;
            o_pump_offset_current <= RST_PUMP_OFFSET;
            o_pump_polarity       <= RST_PUMP_POL;
            o_force_mid_voltage   <= RST_FORCE_MID;
        end else begin
            o_first_locked        <= (lock_state_next == PFCC_LOCKED);
            o_first_fb_div        <= first_fb_div_reg;
            o_first_fb_div_run    <= !first_fb_div_off_reg;
            o_second_fb_div       <= second_fb_div_reg;
            o_second_fb_div_run   <= !second_fb_div_off_reg;
            o_fb_total_div        <= path_div_next;
            o_fb_phase_delay_ps   <= phase_ps_next;
            o_pump_run            <= !pump_off_reg;
            o_pump_sink_on        <= pump_sink_on_reg && !pump_off_reg;
            o_pump_current_ua     <= pump_off_reg ? 12'h000 : pump_ua_next;
            o_pump_offset_current <= pump_offset_current_reg;
            o_pump_polarity       <= pump_polarity_reg;
            o_force_mid_voltage   <= force_mid_voltage_reg;
        end
    end

endmodule // pfcc_top
`default_nettype wire

// ===== testbench/pfcc_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pfcc_checker
    import pfcc_pkg::*;
#(
    parameter logic [23:0] P_LOCK_TICKS_0 = 24'(LOCK_TICKS_0)
) (
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic        i_fb_tick,
    input wire logic        o_first_locked,
    input wire logic [14:0] o_first_fb_div,
    input wire logic        o_first_fb_div_run,
    input wire logic [13:0] o_second_fb_div,
    input wire logic        o_second_fb_div_run,
    input wire logic        o_pump_run,
    input wire logic        o_pump_sink_on,
    input wire logic [11:0] o_pump_current_ua,
    input wire logic [5:0]  o_pump_offset_current,
    input wire logic        o_pump_polarity,
    input wire logic        o_force_mid_voltage
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    logic        addr_mapped;
    logic [23:0] tick_cnt_reg;

    // Address falls inside the block's byte map
    assign addr_mapped = ((i_reg_addr >= ADDR_LOCK_COUNT) && (i_reg_addr <= ADDR_PUMP_POL)) || (i_reg_addr == ADDR_PREDIV);

    // Feedback ticks seen since the lock flag was last high
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) tick_cnt_reg <= '0;
        else if (o_first_locked) tick_cnt_reg <= '0;
        else if (i_fb_tick && (tick_cnt_reg != 24'hFFFFFF)) tick_cnt_reg <= tick_cnt_reg + 24'h1;
    end

    // Run, sink and current expected from a pump control byte
    function automatic logic [13:0] pump_out(input logic [7:0] d);
        if (d[7]) return 14'h0000;
        return {1'b1, d[5], d[4] ? 12'(1600 + 200 * d[2:0]) : 12'(100 * d[3:0])};
    endfunction

    a_rvalid_follows: assert property (o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid does not follow the read strobe");
    a_unmapped_zero: assert property (i_reg_rd && !addr_mapped |=> o_reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");
    a_pump_off_quiet: assert property (!o_pump_run |-> o_pump_current_ua == 12'h000 && !o_pump_sink_on)
        else $error("pump current or sink active while pump off");
    a_force_unlocked: assert property (o_force_mid_voltage |-> !o_first_locked)
        else $error("lock reported while control voltage forced");
    a_div_off_unlocked: assert property (!o_first_fb_div_run |-> !o_first_locked)
        else $error("lock reported while first divider off");
    a_lock_tick_count: assert property ($rose(o_first_locked)
        |-> $past(i_fb_tick) && tick_cnt_reg > P_LOCK_TICKS_0)
        else $error("lock rose too early or without a tick");
    a_div1_write: assert property (i_reg_wr && i_reg_addr == ADDR_FIRST_DIV_LO
        |=> ##1 o_first_fb_div[7:0] == $past(i_reg_wdata, 2)) else $error("first divider low byte not applied");
    a_div2_write: assert property (i_reg_wr && i_reg_addr == ADDR_SECOND_LO
        |=> ##1 o_second_fb_div[7:0] == $past(i_reg_wdata, 2)) else $error("second divider low byte not applied");
    a_div2_power: assert property (i_reg_wr && i_reg_addr == ADDR_PHASE_HI
        |=> ##1 {o_second_fb_div_run, 7'h00} == (~$past(i_reg_wdata, 2) & 8'h80))
        else $error("second divider power state wrong");
    a_pump_write: assert property (i_reg_wr
        && i_reg_addr == ADDR_PUMP_CTRL
        |=> ##1 {o_pump_run, o_pump_sink_on, o_pump_current_ua} == pump_out($past(i_reg_wdata, 2)))
        else $error("pump outputs do not match control byte");
    a_polarity_write: assert property (i_reg_wr && i_reg_addr == ADDR_PUMP_POL
        |=> ##1 {o_pump_polarity, o_force_mid_voltage, o_pump_offset_current} == $past(i_reg_wdata, 2))
        else $error("polarity byte outputs wrong");
endmodule // pfcc_checker
`default_nettype wire

// ===== testbench/pfcc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pfcc_top_test
    import pfcc_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} pfcc_row_t;
    // Reset defaults first, then write and read back with reserved bits cleared
    localparam pfcc_row_t ROWS [26] = '{
        '{1'b0, 8'h13, 8'h00, 8'h00}, '{1'b0, 8'h14, 8'h00, 8'h00}, '{1'b0, 8'h15, 8'h00, 8'h02},
        '{1'b0, 8'h16, 8'h00, 8'h00}, '{1'b0, 8'h17, 8'h00, 8'h01}, '{1'b0, 8'h18, 8'h00, 8'h32},
        '{1'b0, 8'h19, 8'h00, 8'h80}, '{1'b0, 8'h1A, 8'h00, 8'h00}, '{1'b0, 8'h1B, 8'h00, 8'h00},
        '{1'b0, 8'h1C, 8'h00, 8'h30}, '{1'b0, 8'h1D, 8'h00, 8'h40}, '{1'b0, 8'h21, 8'h00, 8'h80},
        '{1'b1, 8'h13, 8'hFF, 8'h30}, '{1'b1, 8'h14, 8'hA5, 8'hA5}, '{1'b1, 8'h15, 8'hFF, 8'hFF},
        '{1'b1, 8'h16, 8'hC3, 8'hC3}, '{1'b1, 8'h17, 8'hFF, 8'h7F}, '{1'b1, 8'h18, 8'h5A, 8'h5A},
        '{1'b1, 8'h19, 8'hFF, 8'hBF}, '{1'b1, 8'h1A, 8'h3C, 8'h3C}, '{1'b1, 8'h1B, 8'hFF, 8'h8F},
        '{1'b1, 8'h1C, 8'hFF, 8'hBF}, '{1'b1, 8'h1D, 8'hFF, 8'hFF}, '{1'b1, 8'h21, 8'hFF, 8'h80},
        '{1'b1, 8'h22, 8'hFF, 8'h00}, '{1'b1, 8'h10, 8'h5A, 8'h00}};
    logic        i_clk_sys, i_sys_rst, i_reg_wr, i_reg_rd, i_fb_tick;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [14:0] i_phase_diff, o_first_fb_div;
    logic        o_reg_rvalid, o_first_locked, o_first_fb_div_run, o_second_fb_div_run;
    logic        o_pump_run, o_pump_sink_on, o_pump_polarity, o_force_mid_voltage;
    logic [13:0] o_second_fb_div;
    logic [29:0] o_fb_total_div;
    logic [20:0] o_fb_phase_delay_ps;
    logic [11:0] o_pump_current_ua;
    logic [5:0]  o_pump_offset_current;
    int          err_count = 0;
    int          num_checks = 0;

    // Lock counts shortened to 2, 3, 4 and 5 ticks
    pfcc_top #(.P_LOCK_TICKS_0(24'd2), .P_LOCK_TICKS_1(24'd3), .P_LOCK_TICKS_2(24'd4), .P_LOCK_TICKS_3(24'd5)) uut (
        .i_clk_sys, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
        .i_fb_tick, .i_phase_diff, .o_first_locked, .o_first_fb_div, .o_first_fb_div_run, .o_second_fb_div,
        .o_second_fb_div_run, .o_fb_total_div, .o_fb_phase_delay_ps, .o_pump_run, .o_pump_sink_on,
        .o_pump_current_ua, .o_pump_offset_current, .o_pump_polarity, .o_force_mid_voltage);

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            err_count++;
            $display("wrong value at %0t: saw %0h, expected %0h", $time, seen, expected);
        end
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1;
        check(32'(o_reg_rvalid), 32'h1);
        check(32'(o_reg_rdata), 32'(e));
    endtask

    // Derived outputs follow a write one edge after the register
    task automatic settle();
        @(posedge i_clk_sys);
        #1;
    endtask

    task automatic fb_tick(input logic [14:0] pd);
        @(posedge i_clk_sys);
        i_fb_tick <= 1'b1;
        i_phase_diff <= pd;
        @(posedge i_clk_sys);
        i_fb_tick <= 1'b0;
        #1;
    endtask

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // Cuts a hung run short
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        err_count++;
        report_and_stop();
    end

    initial begin
        {i_sys_rst, i_reg_wr, i_reg_rd, i_fb_tick, i_reg_addr, i_reg_wdata, i_phase_diff} = {4'h8, 31'h0};
        repeat (10) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        foreach (ROWS[k]) begin
            if (ROWS[k].wr) reg_wr(ROWS[k].addr, ROWS[k].wdata);
            reg_rd(ROWS[k].addr, ROWS[k].rexp);
        end
        // Reset in mid-run restores every default
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        settle();
        check(32'(o_first_fb_div), 32'h200);
        check(32'(o_second_fb_div), 32'h32);
        check(32'(o_fb_total_div), 32'h400);
        check(32'(o_pump_current_ua), 32'd1600);
        check(32'(o_fb_phase_delay_ps), 32'h0);
        check(32'({o_first_fb_div_run, o_second_fb_div_run, o_pump_run, o_pump_sink_on, o_force_mid_voltage,
                   o_pump_polarity, o_first_locked}), 32'h7C);
        // Gain codes 0-15 at the 100uA step and 0-7 at the 200uA step
        for (int m = 0; m < 24; m++) begin
            reg_wr(ADDR_PUMP_CTRL, 8'(32 + m));
            settle();
            check(32'(o_pump_current_ua),
                  (m < 16) ? 32'(m * 100) : 32'(1600 + (m - 16) * 200));
        end
        reg_wr(ADDR_PUMP_CTRL, 8'h1F);
        settle();
        check(32'({o_pump_run, o_pump_sink_on}), 32'h2);
        reg_wr(ADDR_PUMP_CTRL, 8'hBF);
        settle();
        check(32'({o_pump_run, o_pump_current_ua}), 32'h0);
        // Largest divide values and all feedback routes
        reg_wr(ADDR_FIRST_DIV_LO, 8'hFF);
        reg_wr(ADDR_FIRST_DIV_HI, 8'h7F);
        settle();
        check(32'(o_fb_total_div), 32'hFFFE);
        reg_wr(ADDR_SECOND_LO, 8'hFF);
        reg_wr(ADDR_SECOND_HI, 8'h3F);
        settle();
        check(32'(o_fb_total_div), 32'd32767 * 32'd16383);
        reg_wr(ADDR_PREDIV, 8'h00);
        reg_wr(ADDR_SECOND_HI, 8'h80);
        settle();
        check(32'(o_fb_total_div), 32'h7FFF);
        reg_wr(ADDR_PHASE_LO, 8'hFF);
        reg_wr(ADDR_PHASE_HI, 8'h8F);
        settle();
        check(32'({o_second_fb_div_run, o_fb_phase_delay_ps}), 32'd1040130);
        // Window stays at its default, below half the divide value
        repeat (8) fb_tick(15'h0000);
        check(32'(o_first_locked), 32'h0);
        reg_wr(ADDR_PUMP_POL, 8'h00);
        for (int s = 0; s < 4; s++) begin
            reg_wr(ADDR_LOCK_COUNT, 8'(s << 4));
            fb_tick(15'h0101);
            check(32'(o_first_locked), 32'h0);
            repeat (2 + s) fb_tick(15'h0100);
            check(32'(o_first_locked), 32'h0);
            fb_tick(15'h0000);
            check(32'(o_first_locked), 32'h1);
        end
        // Lock drops one edge after the force bit lands
        reg_wr(ADDR_PUMP_POL, 8'h40);
        settle();
        check(32'(o_first_locked), 32'h0);
        reg_wr(ADDR_PUMP_POL, 8'h00);
        repeat (6) fb_tick(15'h0000);
        check(32'(o_first_locked), 32'h1);
        reg_wr(ADDR_FIRST_DIV_HI, 8'hFF);
        repeat (6) fb_tick(15'h0000);
        check(32'({o_first_fb_div_run, o_first_locked}), 32'h0);
        report_and_stop();
    end
endmodule // pfcc_top_test

bind pfcc_top pfcc_checker #(.P_LOCK_TICKS_0(P_LOCK_TICKS_0)) u_checker (
    .i_clk_sys, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
    .i_fb_tick, .o_first_locked, .o_first_fb_div, .o_first_fb_div_run, .o_second_fb_div, .o_second_fb_div_run,
    .o_pump_run, .o_pump_sink_on, .o_pump_current_ua, .o_pump_offset_current, .o_pump_polarity,
    .o_force_mid_voltage);
`default_nettype wire
